/* File: shared/sfrec_params.svh */
// Constants for the serial flash read and erase command block
`ifndef SFREC_PARAMS_SVH
`define SFREC_PARAMS_SVH
// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFREC_OP_FAST 8'h0b
`define SFREC_OP_DOUT 8'h3b
`define SFREC_OP_DIO 8'hbb
`define SFREC_OP_STAT 8'h05
`define SFREC_OP_WU 8'h06
`define SFREC_OP_PAGE 8'h81
`define SFREC_OP_SMALL 8'h20
`define SFREC_OP_HALF 8'h52
`define SFREC_OP_FULL 8'hd8
// ----------------------------------------------------------------------
// Fields and keys
// ----------------------------------------------------------------------
`define SFREC_CONT_KEY 2'h2
`define SFREC_CRM_RST_BYTE 8'hff
`define SFREC_STAT_BUSY_BIT 0
`define SFREC_STAT_WPL_BIT 1
// ----------------------------------------------------------------------
// Frame clock positions (serial clocks counted from chip select low)
// ----------------------------------------------------------------------
`define SFREC_OPC_CLKS 6'h08
`define SFREC_DIO_ADDR_END 6'h14
`define SFREC_ADDR_END 6'h20
`define SFREC_DIO_DATA 6'h18
`define SFREC_FAST_DATA 6'h28
`define SFREC_CRM_CHECK 6'h0b
`define SFREC_FCNT_MAX 6'h3f
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SFREC_SYS_CLK_MHZ 125
`define SFREC_PAGE_WIPE_TIME_US 1000
`define SFREC_SMALL_WIPE_TIME_US 2000
`define SFREC_HALF_BLOCK_WIPE_TIME_US 4000
`define SFREC_FULL_BLOCK_WIPE_TIME_US 8000
`define SFREC_SCLK_DIV 8
`endif

/* File: shared/sfrec_pkg.sv */
// Types shared by both ends of the serial flash command link
package sfrec_pkg;
  typedef enum logic [3:0] {
    SFREC_CMD_FAST = 4'h0,
    SFREC_CMD_DOUT = 4'h1,
    SFREC_CMD_DIO = 4'h2,
    SFREC_CMD_DIO_CONT = 4'h3,
    SFREC_CMD_CRM_RST = 4'h4,
    SFREC_CMD_STAT = 4'h5,
    SFREC_CMD_WU = 4'h6,
    SFREC_CMD_PAGE = 4'h7,
    SFREC_CMD_SMALL = 4'h8,
    SFREC_CMD_HALF = 4'h9,
    SFREC_CMD_FULL = 4'ha
  } sfrec_cmd_t;
  typedef enum logic [1:0] {
    SFREC_WIPE_PAGE = 2'h0,
    SFREC_WIPE_SMALL = 2'h1,
    SFREC_WIPE_HALF = 2'h2,
    SFREC_WIPE_FULL = 2'h3
  } sfrec_wipe_t;
  typedef enum logic [2:0] {
    SFREC_H_IDLE = 3'h0,
    SFREC_H_OPC = 3'h1,
    SFREC_H_ADDR = 3'h2,
    SFREC_H_MODE = 3'h3,
    SFREC_H_DATA = 3'h4,
    SFREC_H_END = 3'h5
  } sfrec_hst_t;
endpackage

/* File: shared/sfrec_if.sv */
// Link between host controller and flash device
`timescale 1ns/10ps
`default_nettype none
interface sfrec_if;
  logic cs_n;
  logic sclk;
  logic h_io0, h_io0_oe, h_io1, h_io1_oe;
  logic d_io0, d_io0_oe, d_io1, d_io1_oe;
  logic io0, io1;
  // Resolved line levels, pulled high when nobody drives
  assign io0 = h_io0_oe ? h_io0 : (d_io0_oe ? d_io0 : 1'b1);
  assign io1 = h_io1_oe ? h_io1 : (d_io1_oe ? d_io1 : 1'b1);
  modport host (output cs_n, sclk, h_io0, h_io0_oe, h_io1, h_io1_oe,
                input io0, io1);
  modport dev (input cs_n, sclk, io0, io1,
               output d_io0, d_io0_oe, d_io1, d_io1_oe);
endinterface
`default_nettype wire

/* File: rtl/sfrec_dev.sv */
// Flash device end: read and erase command handling
// Overview of operation
// - Fast read 0x0B, address, dummy byte, data
// - Sample inputs rising edge, drive falling edge
// - Address increments per byte, wraps to zero
// - Non-status reads refused while busy; cycle continues
// - Chip select high ends read anytime
// - Dual output read 0x3B, eight dummy clocks
// - Dual I/O read 0xBB, two-bit address/data
// - Mode key 10 skips next opcode
// - Other key returns to opcode decoding
// - Reset frame clears continuous mode key
// - Host sends non-10 key unless continuing
// - Erase needs write permit latch set
// - Page wipe 0x81, three address bytes, no dummy
// - Small wipe 0x20, bits 23:12 select
// - Erase needs chip select on boundary
// - Busy during cycle; clears latch after
// - Half block 32K, full block 64K
// - Protected sector or block not erased
// - Protected half block: latch still cleared
// - Upper bidirectional lines ignored in erase
// - Write unlock 0x06 sets permit latch
// - Status read 0x05 allowed any time
`timescale 1ns/10ps
`default_nettype none
`include "sfrec_params.svh"
module sfrec_dev
  import sfrec_pkg::*;
#(
  parameter int unsigned PAGE_WIPE_US = `SFREC_PAGE_WIPE_TIME_US,
  parameter int unsigned SMALL_WIPE_US = `SFREC_SMALL_WIPE_TIME_US,
  parameter int unsigned HALF_WIPE_US = `SFREC_HALF_BLOCK_WIPE_TIME_US,
  parameter int unsigned FULL_WIPE_US = `SFREC_FULL_BLOCK_WIPE_TIME_US
) (
  input wire logic i_sys_clk, // Core clock
  input wire logic i_rst, // Synchronous reset
  sfrec_if.dev link, // Serial link
  input wire logic [4:0] i_block_protect_bits, // Protect setting
  output logic [23:0] o_rd_addr, // Array read address
  input wire logic [7:0] i_rd_data, // Array read data
  output logic o_erase_req, // Erase start pulse
  output sfrec_wipe_t o_erase_kind, // Erase size
  output logic [23:0] o_erase_addr, // Aligned erase address
  output logic o_busy_flag, // Self-timed cycle running
  output logic o_write_permit_latch // Latch state
);
  localparam int unsigned PAGE_CYC = PAGE_WIPE_US * `SFREC_SYS_CLK_MHZ;
  localparam int unsigned SMALL_CYC = SMALL_WIPE_US * `SFREC_SYS_CLK_MHZ;
  localparam int unsigned HALF_CYC = HALF_WIPE_US * `SFREC_SYS_CLK_MHZ;
  localparam int unsigned FULL_CYC = FULL_WIPE_US * `SFREC_SYS_CLK_MHZ;

  function automatic logic is_read_op(input logic [7:0] op);
    is_read_op = (op == `SFREC_OP_FAST) || (op == `SFREC_OP_DOUT) ||
                 (op == `SFREC_OP_DIO) || (op == `SFREC_OP_STAT);
  endfunction

  // ----------------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------------
  logic rst_m_q, rst_s_q, busy_m_q, busy_s_q, wpl_m_q, wpl_s_q;
  logic [5:0] fcnt_q;
  logic [7:0] op_q, mode_q;
  logic [23:0] addr_q;
  logic [2:0] bitp_q;
  logic ign_q, cframe_q, cont_q, armed_q;
  logic cstart, is_dio, is_dout, is_fast, is_stat, is_read, dual_out;
  logic is_erase, data_now, addr_ph, mode_ph, byte_last, crm_hit;
  logic rd_reject;
  logic [5:0] eff, ds;
  logic [7:0] op_eff, op_nx, mode_nx, stat_byte, src;

  // Reset and status levels enter the link domain through two flops
  always_ff @(posedge link.sclk) begin
    rst_m_q <= i_rst;
    rst_s_q <= rst_m_q;
    busy_m_q <= o_busy_flag;
    busy_s_q <= busy_m_q;
    wpl_m_q <= o_write_permit_latch;
    wpl_s_q <= wpl_m_q;
  end

  // A continuous-mode frame starts as if the opcode had just arrived
  assign cstart = (fcnt_q == 6'h00) && cont_q;
  assign eff = cstart ? `SFREC_OPC_CLKS : fcnt_q;
  assign op_eff = cstart ? `SFREC_OP_DIO : op_q;
  assign op_nx = {op_q[6:0], link.io0};
  assign mode_nx = {mode_q[5:0], link.io1, link.io0};
  assign is_dio = op_eff == `SFREC_OP_DIO;
  assign is_dout = op_eff == `SFREC_OP_DOUT;
  assign is_fast = op_eff == `SFREC_OP_FAST;
  assign is_stat = op_eff == `SFREC_OP_STAT;
  assign is_read = is_read_op(op_eff);
  assign dual_out = is_dio || is_dout;
  // Decoding ignores the upper lines entirely
  assign is_erase = (op_q == `SFREC_OP_PAGE) || (op_q == `SFREC_OP_SMALL) ||
                    (op_q == `SFREC_OP_HALF) ||
                    (op_q == `SFREC_OP_FULL);

  // First data clock per command
  always_comb begin
    if (is_fast || is_dout) begin
      ds = `SFREC_FAST_DATA;
    end else if (is_dio) begin
      ds = `SFREC_DIO_DATA;
    end else begin
      ds = `SFREC_OPC_CLKS;
    end
  end

  assign data_now = is_read && !ign_q && (eff >= ds) &&
                    (eff >= `SFREC_OPC_CLKS);
  assign addr_ph = (is_read || is_erase) && (eff >= `SFREC_OPC_CLKS) &&
                   (eff < (is_dio ? `SFREC_DIO_ADDR_END : `SFREC_ADDR_END));
  assign mode_ph = is_dio && (eff >= `SFREC_DIO_ADDR_END) &&
                   (eff < `SFREC_DIO_DATA);
  assign byte_last = bitp_q == (dual_out ? 3'h3 : 3'h7);
  // Reset frame: first two-bit address byte all ones in a keyed frame
  assign crm_hit = cframe_q && (eff == `SFREC_CRM_CHECK) &&
                   ({addr_q[5:0], link.io1, link.io0} ==
                    `SFREC_CRM_RST_BYTE);
  // Status reads stay open while busy so the host can poll the flag
  assign rd_reject = busy_s_q && (cstart ||
                     ((eff == 6'h07) && is_read_op(op_nx) &&
                      (op_nx != `SFREC_OP_STAT)));

  // Per-frame counters, cleared as soon as chip select rises
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      fcnt_q <= 6'h00;
      bitp_q <= 3'h0;
      ign_q <= 1'b0;
      cframe_q <= 1'b0;
    end else begin
      if (eff != `SFREC_FCNT_MAX) begin
        fcnt_q <= eff + 6'h01;
      end
      if (cstart) begin
        cframe_q <= 1'b1;
      end
      if (rd_reject || crm_hit) begin
        ign_q <= 1'b1;
      end
      if (data_now) begin
        bitp_q <= byte_last ? 3'h0 : bitp_q + 3'h1;
      end
    end
  end

  // Opcode, address, mode and the boundary flag survive chip select
  always_ff @(posedge link.sclk) begin
    if (rst_s_q) begin
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      mode_q <= 8'h00;
      cont_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (cstart) begin
        op_q <= `SFREC_OP_DIO;
      end else if (eff < `SFREC_OPC_CLKS) begin
        op_q <= op_nx;
      end
      // Inputs taken on the rising edge
      if (addr_ph) begin
        addr_q <= is_dio ? {addr_q[21:0], link.io1, link.io0}
                         : {addr_q[22:0], link.io0};
      end else if (data_now && byte_last && !is_stat) begin
        addr_q <= addr_q + 24'h000001;
      end
      if (mode_ph) begin
        mode_q <= mode_nx;
      end
      if (crm_hit) begin
        cont_q <= 1'b0;
      end else if (mode_ph && (eff == `SFREC_DIO_DATA - 6'h01) &&
                   !ign_q) begin
        cont_q <= mode_nx[5:4] == `SFREC_CONT_KEY;
      end
      // Any further clock after the exact boundary drops the flag
      armed_q <= !cframe_q && !cstart &&
                 (((eff == 6'h07) && (op_nx == `SFREC_OP_WU)) ||
                  ((eff == `SFREC_ADDR_END - 6'h01) && is_erase));
    end
  end

  assign o_rd_addr = addr_q;
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`SFREC_STAT_BUSY_BIT] = busy_s_q;
    stat_byte[`SFREC_STAT_WPL_BIT] = wpl_s_q;
  end
  assign src = is_stat ? stat_byte : i_rd_data;

  // Output bits change on the falling edge; chip select releases at once
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      link.d_io0 <= 1'b0;
      link.d_io1 <= 1'b0;
      link.d_io0_oe <= 1'b0;
      link.d_io1_oe <= 1'b0;
    end else begin
      link.d_io1_oe <= data_now;
      link.d_io0_oe <= data_now && dual_out;
      if (dual_out) begin
        link.d_io1 <= src[3'h7 - {bitp_q[1:0], 1'b0}];
        link.d_io0 <= src[3'h6 - {bitp_q[1:0], 1'b0}];
      end else begin
        link.d_io1 <= src[3'h7 - bitp_q];
        link.d_io0 <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Core clock domain
  // ----------------------------------------------------------------------
  logic cs_m_q, cs_s_q, cs_d_q, arm_m_q, arm_s_q, cs_rise, prot;
  logic [31:0] cnt_q;
  sfrec_wipe_t kind;
  logic [8:0] nblk;

  always_ff @(posedge i_sys_clk) begin
    cs_m_q <= link.cs_n;
    cs_s_q <= cs_m_q;
    cs_d_q <= cs_s_q;
    arm_m_q <= armed_q;
    arm_s_q <= arm_m_q;
  end
  // Cycle starts on the chip select rising edge
  assign cs_rise = cs_s_q && !cs_d_q;

  always_comb begin
    case (op_q)
      `SFREC_OP_SMALL: kind = SFREC_WIPE_SMALL;
      `SFREC_OP_HALF: kind = SFREC_WIPE_HALF;
      `SFREC_OP_FULL: kind = SFREC_WIPE_FULL;
      default: kind = SFREC_WIPE_PAGE;
    endcase
  end

  // Protected span in 64K blocks: top end, or bottom with bit 3, all with 4
  assign nblk = 9'h001 << (i_block_protect_bits[2:0] - 3'h1);
  assign prot = i_block_protect_bits[4] ||
                ((i_block_protect_bits[2:0] != 3'h0) &&
                 (i_block_protect_bits[3]
                   ? ({1'b0, addr_q[23:16]} < nblk)
                   : ({1'b0, addr_q[23:16]} + nblk >= 9'h100)));

  // Latch, busy flag and erase timer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_busy_flag <= 1'b0;
      o_write_permit_latch <= 1'b0;
      cnt_q <= 32'h00000000;
      o_erase_req <= 1'b0;
      o_erase_kind <= SFREC_WIPE_PAGE;
      o_erase_addr <= 24'h000000;
    end else begin
      o_erase_req <= 1'b0;
      if (o_busy_flag) begin
        cnt_q <= cnt_q - 32'h00000001;
        if (cnt_q == 32'h00000001) begin
          o_busy_flag <= 1'b0;
          o_write_permit_latch <= 1'b0;
        end
      end else if (cs_rise && arm_s_q) begin
        if (op_q == `SFREC_OP_WU) begin
          o_write_permit_latch <= 1'b1;
        end else if (o_write_permit_latch) begin
          if (prot) begin
            o_write_permit_latch <= 1'b0;
          end else begin
            o_busy_flag <= 1'b1;
            o_erase_req <= 1'b1;
            o_erase_kind <= kind;
            case (kind)
              SFREC_WIPE_SMALL: begin
                cnt_q <= SMALL_CYC;
                o_erase_addr <= {addr_q[23:12], 12'h000};
              end
              SFREC_WIPE_HALF: begin
                cnt_q <= HALF_CYC;
                o_erase_addr <= {addr_q[23:15], 15'h0000};
              end
              SFREC_WIPE_FULL: begin
                cnt_q <= FULL_CYC;
                o_erase_addr <= {addr_q[23:16], 16'h0000};
              end
              default: begin
                cnt_q <= PAGE_CYC;
                o_erase_addr <= {addr_q[23:8], 8'h00};
              end
            endcase
          end
        end
      end
    end
  end
endmodule // sfrec_dev
`default_nettype wire

/* File: rtl/sfrec_host.sv */
// Host controller end: frames commands onto the serial link
`timescale 1ns/10ps
`default_nettype none
`include "sfrec_params.svh"
module sfrec_host
  import sfrec_pkg::*;
#(
  parameter int unsigned DIV = `SFREC_SCLK_DIV
) (
  input wire logic i_sys_clk, // Core clock
  input wire logic i_rst, // Synchronous reset
  sfrec_if.host link, // Serial link
  input wire logic i_cmd_valid, // Command request
  input wire sfrec_cmd_t i_cmd, // Command kind
  input wire logic [23:0] i_addr, // Address
  input wire logic [7:0] i_mode, // Continuous mode byte
  input wire logic [7:0] i_rd_len, // Bytes to read
  output logic o_cmd_ready, // Idle, takes command
  output logic o_rd_valid, // Read byte pulse
  output logic [7:0] o_rd_data, // Read byte
  output logic o_done // Frame finished pulse
);
  localparam logic [7:0] PH_LAST = 8'(DIV - 1);
  localparam logic [7:0] PH_RISE = 8'(DIV / 2 - 1);

  function automatic logic [7:0] opcode(input sfrec_cmd_t c);
    case (c)
      SFREC_CMD_FAST: opcode = `SFREC_OP_FAST;
      SFREC_CMD_DOUT: opcode = `SFREC_OP_DOUT;
      SFREC_CMD_DIO: opcode = `SFREC_OP_DIO;
      SFREC_CMD_STAT: opcode = `SFREC_OP_STAT;
      SFREC_CMD_WU: opcode = `SFREC_OP_WU;
      SFREC_CMD_PAGE: opcode = `SFREC_OP_PAGE;
      SFREC_CMD_SMALL: opcode = `SFREC_OP_SMALL;
      SFREC_CMD_HALF: opcode = `SFREC_OP_HALF;
      SFREC_CMD_FULL: opcode = `SFREC_OP_FULL;
      default: opcode = 8'h00;
    endcase
  endfunction

  sfrec_hst_t st_q;
  sfrec_cmd_t cmd_q;
  logic [23:0] sr_q;
  logic [4:0] left_q;
  logic [7:0] len_q, in_q, in_nx, ph_q;
  logic dual_q, drv_q, sclk_q, cs_q, dual_in, is_wipe;
  logic [1:0] io_m_q, io_s_q;

  // Returning lines pass two flops before use
  always_ff @(posedge i_sys_clk) begin
    io_m_q <= {link.io1, link.io0};
    io_s_q <= io_m_q;
  end

  assign dual_in = (cmd_q == SFREC_CMD_DOUT) || (cmd_q == SFREC_CMD_DIO) ||
                   (cmd_q == SFREC_CMD_DIO_CONT);
  assign is_wipe = (cmd_q == SFREC_CMD_PAGE) || (cmd_q == SFREC_CMD_SMALL) ||
                   (cmd_q == SFREC_CMD_HALF) || (cmd_q == SFREC_CMD_FULL);
  // Sample just before the falling edge, well after the device drove
  assign in_nx = dual_q ? {in_q[5:0], io_s_q} : {in_q[6:0], io_s_q[1]};

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= SFREC_H_IDLE;
      cmd_q <= SFREC_CMD_STAT;
      sr_q <= 24'h000000;
      left_q <= 5'h00;
      len_q <= 8'h00;
      in_q <= 8'h00;
      ph_q <= 8'h00;
      dual_q <= 1'b0;
      drv_q <= 1'b0;
      cs_q <= 1'b1;
      // Clocks with chip select high let the far end see the reset;
      // an unknown power-up level still settles into a clean toggle
      if (sclk_q) begin
        sclk_q <= 1'b0;
      end else begin
        sclk_q <= 1'b1;
      end
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      o_done <= 1'b0;
      case (st_q)
        SFREC_H_IDLE: begin
          cs_q <= 1'b1;
          sclk_q <= 1'b0;
          ph_q <= 8'h00;
          if (i_cmd_valid) begin
            cmd_q <= i_cmd;
            len_q <= i_rd_len;
            cs_q <= 1'b0;
            drv_q <= 1'b1;
            if (i_cmd == SFREC_CMD_DIO_CONT) begin
              st_q <= SFREC_H_ADDR;
              sr_q <= i_addr;
              dual_q <= 1'b1;
              left_q <= 5'h0c;
            end else if (i_cmd == SFREC_CMD_CRM_RST) begin
              st_q <= SFREC_H_ADDR;
              sr_q <= {`SFREC_CRM_RST_BYTE, 16'h0000};
              dual_q <= 1'b1;
              left_q <= 5'h04;
            end else begin
              st_q <= SFREC_H_OPC;
              sr_q <= {opcode(i_cmd), 16'h0000};
              dual_q <= 1'b0;
              left_q <= 5'h08;
            end
          end
        end
        SFREC_H_END: begin
          cs_q <= 1'b1;
          sclk_q <= 1'b0;
          drv_q <= 1'b0;
          ph_q <= ph_q + 8'h01;
          if (ph_q == PH_LAST) begin
            st_q <= SFREC_H_IDLE;
            o_done <= 1'b1;
          end
        end
        default: begin
          ph_q <= (ph_q == PH_LAST) ? 8'h00 : ph_q + 8'h01;
          sclk_q <= (ph_q >= PH_RISE) && (ph_q != PH_LAST);
          if (ph_q == PH_LAST) begin
            sr_q <= dual_q ? {sr_q[21:0], 2'h0} : {sr_q[22:0], 1'b0};
            left_q <= left_q - 5'h01;
            if (st_q == SFREC_H_DATA) begin
              in_q <= in_nx;
            end
            if (left_q == 5'h01) begin
              case (st_q)
                SFREC_H_OPC: begin
                  if (cmd_q == SFREC_CMD_WU) begin
                    st_q <= SFREC_H_END;
                  end else if (cmd_q == SFREC_CMD_STAT) begin
                    st_q <= SFREC_H_DATA;
                    drv_q <= 1'b0;
                    left_q <= 5'h08;
                  end else begin
                    st_q <= SFREC_H_ADDR;
                    sr_q <= i_addr;
                    dual_q <= cmd_q == SFREC_CMD_DIO;
                    left_q <= (cmd_q == SFREC_CMD_DIO) ? 5'h0c : 5'h18;
                  end
                end
                SFREC_H_ADDR: begin
                  if (is_wipe || (cmd_q == SFREC_CMD_CRM_RST)) begin
                    st_q <= SFREC_H_END;
                  end else begin
                    st_q <= SFREC_H_MODE;
                    sr_q <= {i_mode, 16'h0000};
                    left_q <= dual_q ? 5'h04 : 5'h08;
                  end
                end
                SFREC_H_MODE: begin
                  st_q <= SFREC_H_DATA;
                  drv_q <= 1'b0;
                  dual_q <= dual_in;
                  left_q <= dual_in ? 5'h04 : 5'h08;
                end
                default: begin
                  o_rd_valid <= 1'b1;
                  o_rd_data <= in_nx;
                  left_q <= dual_q ? 5'h04 : 5'h08;
                  len_q <= len_q - 8'h01;
                  if (len_q <= 8'h01) begin
                    st_q <= SFREC_H_END;
                  end
                end
              endcase
              if ((st_q != SFREC_H_DATA) || (len_q <= 8'h01)) begin
                ph_q <= 8'h00;
              end
            end
          end
        end
      endcase
    end
  end

  // Pin drive
  assign o_cmd_ready = (st_q == SFREC_H_IDLE) && !i_rst;
  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.h_io1 = sr_q[23];
  assign link.h_io0 = dual_q ? sr_q[22] : sr_q[23];
  assign link.h_io0_oe = drv_q;
  assign link.h_io1_oe = drv_q && dual_q;
endmodule // sfrec_host
`default_nettype wire

/* File: dv/sfrec_link_monitor.sv */
// Concurrent checks on the serial link between host and device
`timescale 1ns/10ps
`default_nettype none
module sfrec_link_monitor (
  input wire logic i_sys_clk, // Core clock
  input wire logic i_rst, // Sync reset
  input wire logic cs_n, // Chip select
  input wire logic sclk, // Serial clock
  input wire logic h_io0, // Host line 0
  input wire logic h_io0_oe, // Host enable 0
  input wire logic h_io1_oe, // Host enable 1
  input wire logic d_io0_oe, // Device enable 0
  input wire logic d_io1, // Device line 1
  input wire logic d_io1_oe // Device enable 1
);
  // ------------------------------------------------------------
  // Link timing
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_sclk_high;
    sclk[*4] ##1 !sclk;
  endsequence
  sequence s_cs_gap;
    cs_n[*4];
  endsequence
  property p_one_drv0;
    !(h_io0_oe && d_io0_oe);
  endproperty
  property p_one_drv1;
    !(h_io1_oe && d_io1_oe);
  endproperty
  // Deselected device must let the lines float to the pull-up
  property p_release;
    cs_n[*3] |-> !d_io0_oe && !d_io1_oe;
  endproperty
  // Past reset guards the first edge, when sclk still toggles
  property p_sclk_idle;
    $past(i_rst) == 1'b0 && cs_n && $past(cs_n) |-> !sclk;
  endproperty
  property p_sclk_shape;
    $rose(sclk) && !cs_n |-> s_sclk_high;
  endproperty
  property p_cs_gap;
    $rose(cs_n) |-> s_cs_gap;
  endproperty
  property p_dev_edge;
    !cs_n && $changed(d_io1) |-> !sclk;
  endproperty
  property p_host_edge;
    !cs_n && $changed(h_io0) |-> !sclk;
  endproperty
  a_one_drv0: assert property (p_one_drv0)
    else $error("both ends drive line 0");
  a_one_drv1: assert property (p_one_drv1)
    else $error("both ends drive line 1");
  a_release: assert property (p_release)
    else $error("device drives while deselected");
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock not idle low");
  a_sclk_shape: assert property (p_sclk_shape)
    else $error("serial clock high phase wrong");
  a_cs_gap: assert property (p_cs_gap)
    else $error("chip select gap too short");
  a_dev_edge: assert property (p_dev_edge)
    else $error("device data changed with clock high");
  a_host_edge: assert property (p_host_edge)
    else $error("host data changed with clock high");
endmodule // sfrec_link_monitor
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench joining host and flash device ends
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sfrec_pkg::*;
  logic i_sys_clk, i_rst, cmd_v, busy, er_req, rv, done, wpl, rdy;
  sfrec_cmd_t cmd;
  sfrec_wipe_t er_kind;
  logic [23:0] addr, rd_addr, er_addr;
  logic [7:0] mode, len, rdat;
  logic [4:0] bp;
  logic [7:0] got[$];
  int failures, comparisons, n_er, cyc, j;
  sfrec_cmd_t cm[4] = '{SFREC_CMD_PAGE, SFREC_CMD_SMALL, SFREC_CMD_HALF,
    SFREC_CMD_FULL};
  logic [23:0] ex[4] = '{24'h5a9b00, 24'h5a9000, 24'h5a8000, 24'h5a0000};
  sfrec_if lnk();
  sfrec_host sfrec_host_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .link(lnk.host), .i_cmd_valid(cmd_v), .i_cmd(cmd), .i_addr(addr),
    .i_mode(mode), .i_rd_len(len), .o_cmd_ready(rdy), .o_rd_valid(rv),
    .o_rd_data(rdat), .o_done(done));
  // Long wipe time keeps busy up across a status and a read frame
  sfrec_dev #(.PAGE_WIPE_US(8), .SMALL_WIPE_US(8), .HALF_WIPE_US(8),
    .FULL_WIPE_US(8)) sfrec_dev_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .link(lnk.dev), .i_block_protect_bits(bp), .o_rd_addr(rd_addr),
    .i_rd_data(rd_addr[7:0] ^ rd_addr[23:16]), .o_erase_req(er_req),
    .o_erase_kind(er_kind), .o_erase_addr(er_addr), .o_busy_flag(busy),
    .o_write_permit_latch(wpl));
  sfrec_link_monitor sfrec_link_monitor_i (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .h_io0(lnk.h_io0),
    .h_io0_oe(lnk.h_io0_oe), .h_io1_oe(lnk.h_io1_oe),
    .d_io0_oe(lnk.d_io0_oe), .d_io1(lnk.d_io1), .d_io1_oe(lnk.d_io1_oe));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [23:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task stop_test();
    $display("checks %0d errors %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One frame; address and mode stay put until the frame is done
  task run(input sfrec_cmd_t c, input logic [23:0] a,
           input logic [7:0] m, n);
    int k;
    @(posedge i_sys_clk);
    chk("ready", 24'(rdy), 24'h000001);
    got = {};
    cmd_v <= 1'b1;
    cmd <= c;
    addr <= a;
    mode <= m;
    len <= n;
    @(posedge i_sys_clk);
    cmd_v <= 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge i_sys_clk);
    if (k == 3000) failures++;
  endtask
  task rd(input sfrec_cmd_t c, input logic [23:0] a,
          input logic [7:0] m, input int n, input bit b);
    logic [23:0] x;
    int i;
    run(c, a, m, 8'(n));
    chk("count", 24'(got.size()), 24'(n));
    for (i = 0; i < n; i++) begin
      x = a + 24'(i);
      chk("byte", 24'(got[i]), b ? 24'hff : 24'(x[7:0] ^ x[23:16]));
    end
  endtask
  task stat(input logic [7:0] s);
    run(SFREC_CMD_STAT, 24'h0, 8'h00, 8'h01);
    chk("status", 24'(got[0]), 24'(s));
    chk("latch", 24'(wpl), 24'(s[1]));
  endtask
  task wipe(input sfrec_cmd_t c, input logic [23:0] a, e,
            input sfrec_wipe_t k, input int n, input bit go);
    int i;
    run(c, a, 8'h00, 8'h00);
    chk("wipes", 24'(n_er), 24'(n));
    if (go) begin
      chk("wipe addr", er_addr, e);
      chk("wipe kind", 24'(er_kind), 24'(k));
      stat(8'h03);
      rd(SFREC_CMD_FAST, a, 8'h00, 1, 1'b1);
      for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge i_sys_clk);
      if (i == 3000) failures++;
    end
    stat(8'h00);
  endtask
  // Byte capture, wipe counting and the hang limit
  always @(posedge i_sys_clk) begin
    cyc++;
    if (rv) got.push_back(rdat);
    if (er_req) n_er++;
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    {cmd_v, addr, mode, len, bp} = '0;
    cmd = SFREC_CMD_STAT;
    i_rst = 1'b1;
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    wipe(SFREC_CMD_SMALL, 24'h123456, 0, SFREC_WIPE_SMALL, 0, 0);
    run(SFREC_CMD_WU, 0, 0, 0);
    stat(8'h02);
    rd(SFREC_CMD_FAST, 24'hfffffe, 0, 3, 0);
    rd(SFREC_CMD_DOUT, 24'h01234f, 0, 2, 0);
    rd(SFREC_CMD_DIO, 24'h00a0ff, 8'h20, 2, 0);
    rd(SFREC_CMD_DIO_CONT, 24'h3c0001, 8'h20, 2, 0);
    run(SFREC_CMD_CRM_RST, 24'hffffff, 8'h00, 1);
    rd(SFREC_CMD_FAST, 24'h000010, 0, 1, 0);
    rd(SFREC_CMD_DIO, 24'h000200, 8'h00, 1, 0);
    rd(SFREC_CMD_FAST, 24'h000300, 0, 1, 0);
    for (j = 0; j < 4; j++) begin
      run(SFREC_CMD_WU, 0, 0, 0);
      wipe(cm[j], 24'h5a9bcd, ex[j], sfrec_wipe_t'(j), j + 1, 1);
    end
    bp <= 5'h10;
    run(SFREC_CMD_WU, 0, 0, 0);
    wipe(SFREC_CMD_HALF, 24'h010000, 0, SFREC_WIPE_HALF, 4, 0);
    run(SFREC_CMD_WU, 0, 0, 0);
    wipe(SFREC_CMD_FULL, 24'h020000, 0, SFREC_WIPE_FULL, 4, 0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
